// file: pkg/pwm_access_cfg.svh
// Constants for the modulator control and local-register access block.
// Assumes inclusion by bare name from the package and the design files.
`ifndef PWM_ACCESS_CFG_SVH
`define PWM_ACCESS_CFG_SVH
`define PWM_CTRL_ADDR 4'h6
`define PWM_DATA_ADDR 4'h5
`define PWM_SYNC_ADDR 4'h7
`define PWM_CTRL_RESET 16'h0000
`define PWM_CTRL_WMASK 16'h11F3
`define PWM_MEN_BIT 12
`define PWM_UPD_BIT 8
`define PWM_SEL_HI 7
`define PWM_SEL_LO 4
`define PWM_REG_HI 1
`define PWM_REG_LO 0
`define PWM_LAST_CH 4'h9
`define PWM_NUM_CH 10
`define PWM_DUTY_RESET 16'h0000
`endif

// file: pkg/pwm_access_pkg.sv
// Types shared by the modulator access block and its channel bank.
// Assumes the constants header is on the include path.
`default_nettype none
`include "pwm_access_cfg.svh"
package pwm_access_pkg;
   typedef enum logic [1:0] {
      LOCAL_DUTY,
      LOCAL_CONFIG,
      LOCAL_DELAY
   } local_sel_type;
   typedef logic [15:0] word_type;
endpackage
`default_nettype wire

// file: pkg/pwm_bank_if.sv
// Signals between the access front end and the channel register bank.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface pwm_bank_if;
   import pwm_access_pkg::*;
   logic wr;
   logic [3:0] chan;
   local_sel_type sel;
   word_type wdata;
   word_type rdata;
   logic update;
   modport front (output wr, output chan, output sel, output wdata, output update,
      input rdata);
   modport bank (input wr, input chan, input sel, input wdata, input update,
      output rdata);
endinterface
`default_nettype wire

// file: rtl/pwm_channel_bank.sv
// Per-channel local registers: duty holding stage, live duty, config, delay.
// Assumes the front end only presents channel numbers 0 to NUM_CH-1.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_access_cfg.svh"
module pwm_channel_bank #(
   parameter int NUM_CH = `PWM_NUM_CH
) (
   // Clock and power-on reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // Front end
   pwm_bank_if.bank bus,
   // Channel state
   output pwm_access_pkg::word_type o_duty_live [NUM_CH],
   output pwm_access_pkg::word_type o_config [NUM_CH],
   output pwm_access_pkg::word_type o_delay [NUM_CH]
);
   import pwm_access_pkg::*;
   word_type duty_hold [NUM_CH];
   word_type rd_duty, rd_cfg, rd_dly;
   assign rd_duty = duty_hold[bus.chan];
   assign rd_cfg = o_config[bus.chan];
   assign rd_dly = o_delay[bus.chan];
   // R12
   assign bus.rdata = (bus.sel == LOCAL_DUTY) ? rd_duty :
      (bus.sel == LOCAL_CONFIG) ? rd_cfg : rd_dly;
   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      wire hit = bus.wr && (bus.chan == 4'(c));
      always_ff @(posedge i_clk or negedge i_rstn) begin
         if (!i_rstn) begin
            duty_hold[c] <= `PWM_DUTY_RESET;
            o_duty_live[c] <= `PWM_DUTY_RESET;
            o_config[c] <= `PWM_DUTY_RESET;
            o_delay[c] <= `PWM_DUTY_RESET;
         end else begin
            if (hit && bus.sel == LOCAL_DUTY) duty_hold[c] <= bus.wdata; // R05 R08
            if (hit && bus.sel == LOCAL_CONFIG) o_config[c] <= bus.wdata; // R08
            if (hit && bus.sel == LOCAL_DELAY) o_delay[c] <= bus.wdata; // R08
            // Write and update together: the fresh value goes live at once
            if (bus.update) o_duty_live[c] <= hit && bus.sel == LOCAL_DUTY ?
               bus.wdata : duty_hold[c]; // R04
         end
      end
   end
   upd_holds_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // R05
      !bus.update |=> o_duty_live[0] == $past(o_duty_live[0]))
      else $error("live duty changed without update");
   upd_copies_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // R04
      bus.update && !bus.wr |=> o_duty_live[NUM_CH-1] == $past(duty_hold[NUM_CH-1]))
      else $error("update did not copy duty");
endmodule
`default_nettype wire

// file: rtl/pwm_access.sv
// Control register and indirect local-register access for ten channels.
// Assumes a single-cycle register port from the core, and that i_rstn is
// the power-on reset alone; other resets must not reach it.
// Operation
// [R01] Control, data and sync registers clear only on power-on reset.
// [R02] Control bit 12 is a master enable; no channel runs while it is zero.
// [R03] Software sets the master enable only after writing the local registers.
// [R04] Writing one to control bit 8 moves all pending duties live in one cycle.
// [R05] A new duty waits in a holding stage until the update bit is set.
// [R06] The update bit clears itself after one core clock.
// [R07] Control bits 7:4 pick channel 0 to 9 for the data register.
// [R08] Each channel has duty, configuration and start-delay local registers.
// [R09] Every data register read or write advances the channel pointer by one.
// [R10] Pointer bits 1:0: 00 duty, 01 configuration, 1x start delay.
// [R11] Software writes zero to reserved control bits and leaves them alone.
// [R12] Data register accesses go to the local register the pointers select.
// [R13] Reserved control bits read as zero and ignore writes.
// [R14] The channel pointer wraps from 9 back to 0.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_access_cfg.svh"
module pwm_access #(
   parameter int NUM_CH = `PWM_NUM_CH
) (
   // Clock and power-on reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // Core register port
   input wire logic [3:0] i_addr,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire pwm_access_pkg::word_type i_wdata,
   output pwm_access_pkg::word_type o_rdata,
   // Channel state
   output logic o_master_en,
   output logic [NUM_CH-1:0] o_chan_run,
   output pwm_access_pkg::word_type o_duty_live [NUM_CH],
   output pwm_access_pkg::word_type o_config [NUM_CH],
   output pwm_access_pkg::word_type o_delay [NUM_CH],
   output pwm_access_pkg::word_type o_sync
);
   import pwm_access_pkg::*;

   word_type ctrl;
   pwm_bank_if bank_bus ();

   function automatic local_sel_type decode_sel(input logic [1:0] code);
      return code[1] ? LOCAL_DELAY : (code[0] ? LOCAL_CONFIG : LOCAL_DUTY); // R10
   endfunction

   wire ctrl_sel = (i_addr == `PWM_CTRL_ADDR);
   wire data_sel = (i_addr == `PWM_DATA_ADDR);
   wire sync_sel = (i_addr == `PWM_SYNC_ADDR);
   wire ctrl_wr = i_wr && ctrl_sel;
   wire data_wr = i_wr && data_sel;
   // A read of the window steps the pointer just as a write does
   wire data_acc = (i_wr || i_rd) && data_sel;
   wire sync_wr = i_wr && sync_sel;
   wire [3:0] chan_ptr = ctrl[`PWM_SEL_HI:`PWM_SEL_LO];
   wire [1:0] local_code = ctrl[`PWM_REG_HI:`PWM_REG_LO];
   // Out-of-range pointer written by software is mapped onto channel 0
   wire [3:0] chan_eff = (chan_ptr > `PWM_LAST_CH) ? 4'h0 : chan_ptr; // R07
   wire [3:0] chan_next = (chan_eff == `PWM_LAST_CH) ? 4'h0 : chan_eff + 4'h1; // R14
   // Only writable bits are kept; the rest stay zero
   wire [15:0] ctrl_written = i_wdata & `PWM_CTRL_WMASK; // R13

   assign bank_bus.wr = data_wr;
   assign bank_bus.chan = chan_eff; // R07
   assign bank_bus.sel = decode_sel(local_code); // R10
   assign bank_bus.wdata = i_wdata;
   assign bank_bus.update = ctrl[`PWM_UPD_BIT]; // R04

   // R01
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ctrl <= `PWM_CTRL_RESET;
      end else if (ctrl_wr) begin
         ctrl <= ctrl_written;
      end else begin
         ctrl[`PWM_UPD_BIT] <= 1'b0; // R06
         if (data_acc) ctrl[`PWM_SEL_HI:`PWM_SEL_LO] <= chan_next; // R09
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) o_sync <= `PWM_CTRL_RESET; // R01
      else if (sync_wr) o_sync <= i_wdata;
   end

   wire [15:0] next_rdata = ctrl_sel ? ctrl :
      data_sel ? bank_bus.rdata : // R12
      sync_sel ? o_sync : 16'h0000;
   assign o_rdata = next_rdata;

   assign o_master_en = ctrl[`PWM_MEN_BIT];
   // Channel config may request run, but master enable gates every one
   for (genvar c = 0; c < NUM_CH; c++) begin : g_run
      assign o_chan_run[c] = o_master_en && o_config[c][`PWM_MEN_BIT]; // R02
      cfg_write_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // R08
         data_wr && chan_eff == 4'(c) && local_code == 2'b01
         |=> o_config[c] == $past(i_wdata))
         else $error("config write lost");
      // A write to one channel must leave every other channel alone
      cfg_other_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // R12
         data_wr && chan_eff != 4'(c)
         |=> o_config[c] == $past(o_config[c]) && o_delay[c] == $past(o_delay[c]))
         else $error("write reached a channel not selected");
   end

   pwm_channel_bank #(.NUM_CH(NUM_CH)) u_bank (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .bus(bank_bus.bank),
      .o_duty_live(o_duty_live),
      .o_config(o_config),
      .o_delay(o_delay)
   );

   // Reset is the only way back to zero, so both are checked while it is held
   rst_clear_a: assert property (@(posedge i_clk) // R01
      !i_rstn ##1 !i_rstn |-> ctrl == `PWM_CTRL_RESET && o_sync == `PWM_CTRL_RESET)
      else $error("control or sync not cleared by reset");
   rst_bank_a: assert property (@(posedge i_clk) // R01
      !i_rstn ##1 !i_rstn |-> o_duty_live[0] == `PWM_DUTY_RESET
      && o_config[0] == `PWM_DUTY_RESET
      && o_delay[NUM_CH-1] == `PWM_DUTY_RESET)
      else $error("local registers not cleared by reset");
   ctrl_hold_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // R01
      !ctrl_wr && !data_acc && !ctrl[`PWM_UPD_BIT] |=> ctrl == $past(ctrl))
      else $error("control changed with no cause");
   sync_hold_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // R01
      !sync_wr |=> o_sync == $past(o_sync))
      else $error("sync register changed with no write");

   // Update strobe
   upd_clears_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // R06
      ctrl[`PWM_UPD_BIT] && !ctrl_wr |=> !ctrl[`PWM_UPD_BIT])
      else $error("update bit did not self clear");
   upd_sets_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // R04
      ctrl_wr && i_wdata[`PWM_UPD_BIT] |=> ctrl[`PWM_UPD_BIT] ##1 !ctrl[`PWM_UPD_BIT])
      else $error("update strobe not one cycle");
   upd_write_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // R04
      data_wr && ctrl[`PWM_UPD_BIT] && bank_bus.sel == LOCAL_DUTY
      |=> o_duty_live[$past(chan_eff)] == $past(i_wdata))
      else $error("duty written in update cycle not live");
   duty_wait_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // R05
      data_wr && !ctrl[`PWM_UPD_BIT] && bank_bus.sel == LOCAL_DUTY
      |=> o_duty_live[$past(chan_eff)] == $past(o_duty_live[chan_eff]))
      else $error("duty went live before update");

   // Master enable and control writes
   men_gates_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // R02
      !o_master_en |-> o_chan_run == '0)
      else $error("channel running without master enable");
   men_write_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // R02
      ctrl_wr |=> o_master_en == $past(i_wdata[`PWM_MEN_BIT]))
      else $error("master enable not taken from write");
   ctrl_write_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // R13
      ctrl_wr |=> ctrl == ($past(i_wdata) & `PWM_CTRL_WMASK))
      else $error("control write not masked");
   resv_zero_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // R13
      (ctrl & ~`PWM_CTRL_WMASK) == 16'h0000)
      else $error("reserved control bit set");
   rd_resv_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // R13
      ctrl_sel |-> (o_rdata & ~`PWM_CTRL_WMASK) == 16'h0000)
      else $error("reserved control bit read back");

   // Channel pointer
   ptr_step_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // R09
      data_acc && !ctrl_wr && chan_ptr < `PWM_LAST_CH |=> chan_ptr == $past(chan_ptr) + 4'h1)
      else $error("channel pointer did not advance");
   ptr_wrap_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // R14
      data_acc && !ctrl_wr && chan_ptr == `PWM_LAST_CH |=> chan_ptr == 4'h0)
      else $error("channel pointer did not wrap");
   ptr_oob_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // R07
      data_acc && !ctrl_wr && chan_ptr > `PWM_LAST_CH |=> chan_ptr == 4'h1)
      else $error("out of range pointer not taken as channel 0");
   ptr_hold_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // R09
      !data_acc && !ctrl_wr |=> chan_ptr == $past(chan_ptr))
      else $error("channel pointer moved without access");
   step_keeps_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // R09
      data_acc && !ctrl_wr
      |=> local_code == $past(local_code) && o_master_en == $past(o_master_en))
      else $error("pointer step disturbed other fields");

   // Local register routing
   sel_route_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // R10
      ctrl[`PWM_REG_HI] |-> bank_bus.sel == LOCAL_DELAY)
      else $error("start delay not selected");
   data_wr_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // R12
      data_wr && local_code == 2'b01 && chan_eff == 4'h0 |=> o_config[0] == $past(i_wdata))
      else $error("config write lost");
   dly_write_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // R10
      data_wr && local_code[1] |=> o_delay[$past(chan_eff)] == $past(i_wdata))
      else $error("start delay write lost");
   rd_config_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // R12
      data_sel && local_code == 2'b01 |-> o_rdata == o_config[chan_eff])
      else $error("config read misrouted");
   rd_delay_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // R10
      data_sel && local_code[1] |-> o_rdata == o_delay[chan_eff])
      else $error("start delay read misrouted");
   rd_no_write_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // R12
      i_rd && !i_wr && data_sel |=> o_config[$past(chan_eff)] == $past(o_config[chan_eff]))
      else $error("window read changed a local register");

   cv_update_c: cover property (@(posedge i_clk) disable iff (!i_rstn)
      ctrl_wr && i_wdata[`PWM_UPD_BIT]);
   cv_wrap_c: cover property (@(posedge i_clk) disable iff (!i_rstn)
      data_acc && chan_ptr == `PWM_LAST_CH);
   cv_enable_c: cover property (@(posedge i_clk) disable iff (!i_rstn) o_chan_run != '0);
   cv_oob_c: cover property (@(posedge i_clk) disable iff (!i_rstn)
      data_acc && chan_ptr > `PWM_LAST_CH);
   cv_live_write_c: cover property (@(posedge i_clk) disable iff (!i_rstn)
      data_wr && ctrl[`PWM_UPD_BIT]);
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking bench for the modulator control and local-register access block.
// Assumes the access package is compiled first; the bench drives the register port.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import pwm_access_pkg::*;
   logic i_clk = 1'b0;
   logic i_rstn = 1'b0;
   logic [3:0] addr = 4'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   word_type wdata = 16'h0000;
   word_type rdata, sync_o, mctrl, msync;
   logic men;
   logic [9:0] run;
   word_type live_o [10], cfg_o [10], dly_o [10];
   word_type hold [10], live [10], mcfg [10], mdly [10];
   integer seed = 32'h2E3447B2;
   int mismatches = 0;
   int n_checks = 0;

   always #12.5 i_clk = ~i_clk;

   pwm_access #(.NUM_CH(10)) i_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_addr(addr),
      .i_wr(wr), .i_rd(rd), .i_wdata(wdata), .o_rdata(rdata), .o_master_en(men),
      .o_chan_run(run), .o_duty_live(live_o), .o_config(cfg_o), .o_delay(dly_o),
      .o_sync(sync_o));

   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input word_type seen, input word_type exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic model_reset();
      foreach (hold[k]) begin
         hold[k] = 16'h0000; live[k] = 16'h0000; mcfg[k] = 16'h0000; mdly[k] = 16'h0000;
      end
      mctrl = 16'h0000;
      msync = 16'h0000;
   endtask

   task automatic chk_all();
      for (int k = 0; k < 10; k++) begin
         chk(live_o[k], live[k]);
         chk(cfg_o[k], mcfg[k]);
         chk(dly_o[k], mdly[k]);
         chk({15'h0000, run[k]}, {15'h0000, mctrl[12] & mcfg[k][12]});
      end
      chk({15'h0000, men}, {15'h0000, mctrl[12]});
      chk(sync_o, msync);
   endtask

   // One register access per cycle; strobes stay up so back-to-back calls never clash
   task automatic acc(input logic [3:0] a, input logic w, input word_type d);
      int ch;
      word_type e;
      ch = (mctrl[7:4] > 4'h9) ? 0 : int'(mctrl[7:4]);
      case (a)
         4'h6: e = mctrl;
         4'h7: e = msync;
         4'h5: e = (mctrl[1:0] == 2'b00) ? hold[ch] : (mctrl[1:0] == 2'b01) ? mcfg[ch] : mdly[ch];
         default: e = 16'h0000;
      endcase
      addr <= a;
      wr <= w;
      rd <= !w;
      wdata <= d;
      #1;
      chk_all();
      if (!w) chk(rdata, e);
      @(posedge i_clk);
      // Local writes land first, so a duty written in the update cycle goes live at once
      if (w && a == 4'h5) begin
         if (mctrl[1:0] == 2'b00) hold[ch] = d;
         else if (mctrl[1:0] == 2'b01) mcfg[ch] = d;
         else mdly[ch] = d;
      end
      if (mctrl[8]) begin
         live = hold;
         mctrl[8] = 1'b0;
      end
      if (w && a == 4'h6) mctrl = d & 16'h11F3;
      if (w && a == 4'h7) msync = d;
      if (a == 4'h5) mctrl[7:4] = (ch == 9) ? 4'h0 : 4'(ch + 1);
   endtask

   initial begin
      model_reset();
      repeat (10) @(posedge i_clk);
      i_rstn <= 1'b1;
      @(posedge i_clk);
      acc(4'h6, 1'b0, 16'h0000);
      acc(4'h5, 1'b0, 16'h0000);
      acc(4'h6, 1'b1, (16'($random(seed)) & 16'hEE0F) | 16'h0070);
      acc(4'h6, 1'b0, 16'h0000);
      for (int s = 0; s < 4; s++) begin
         acc(4'h6, 1'b1, 16'h0070 | 16'(s));
         for (int j = 0; j < 10; j++) acc(4'h5, 1'b1, 16'($random(seed)));
         acc(4'h6, 1'b0, 16'h0000);
      end
      for (int s = 0; s < 4; s++) begin
         acc(4'h6, 1'b1, 16'h0070 | 16'(s));
         for (int j = 0; j < 10; j++) acc(4'h5, 1'b0, 16'h0000);
      end
      acc(4'h7, 1'b1, 16'($random(seed)));
      acc(4'h7, 1'b0, 16'h0000);
      acc(4'h3, 1'b0, 16'h0000);
      acc(4'h6, 1'b1, 16'h1100);
      acc(4'h6, 1'b0, 16'h0000);
      acc(4'h6, 1'b0, 16'h0000);
      acc(4'h6, 1'b1, 16'h1030);
      acc(4'h5, 1'b1, 16'($random(seed)));
      acc(4'h3, 1'b0, 16'h0000);
      acc(4'h6, 1'b1, 16'h1140);
      acc(4'h5, 1'b1, 16'($random(seed)));
      acc(4'h3, 1'b0, 16'h0000);
      acc(4'h6, 1'b1, 16'h00F1);
      acc(4'h5, 1'b0, 16'h0000);
      acc(4'h6, 1'b0, 16'h0000);
      i_rstn <= 1'b0;
      wr <= 1'b0;
      rd <= 1'b0;
      repeat (2) @(posedge i_clk);
      model_reset();
      #1;
      chk_all();
      @(posedge i_clk);
      i_rstn <= 1'b1;
      @(posedge i_clk);
      acc(4'h6, 1'b0, 16'h0000);
      acc(4'h3, 1'b0, 16'h0000);
      end_of_test();
   end

   // Run needs about 130 cycles; the limit leaves a wide margin
   initial begin
      repeat (2000) @(posedge i_clk);
      mismatches++;
      end_of_test();
   end
endmodule
`default_nettype wire
